/* File: clock_synth_program_ctrl.sv */
// module: clock synth table images, generator programming, post-dividers and measurement
`timescale 1ns/1ns
module clock_synth_program_ctrl
  import synth_ctrl_pkg::*;
#(
  parameter logic [31:0] GATE_COUNT = 32'(GATE_CYCLES)
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // generator outputs
  input wire logic i_generator_output_a,
  input wire logic i_generator_output_b,
  input wire logic i_generator_output_c,
  input wire logic i_generator_output_d,
  // serial programming link
  input wire logic i_synth_ack,
  output logic o_synth_sclk,
  output logic o_synth_sdata,
  output logic o_synth_sel_one,
  output logic o_synth_sel_two,
  // lane baud sources
  output logic o_lane1_baud_source,
  output logic o_lane2_baud_source,
  output logic o_lane3_baud_source,
  output logic o_lane4_baud_source,
  // interrupt
  output logic o_irq
);

  typedef struct packed {
    logic [7:0] addr;
    logic [TABLE_DEPTH-1:0][7:0] tab_one;
    logic [TABLE_DEPTH-1:0][7:0] tab_two;
    logic [23:0] ctrl;
    logic [2:0] flags;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ser_state_e st;
    logic chip;
    logic [7:0] idx;
    logic [15:0] shreg;
    logic [4:0] bits;
    logic [7:0] div;
    logic sclk;
    logic sdata;
    logic sel_one;
    logic sel_two;
    logic meas_run;
    logic [1:0] msel;
    logic [31:0] gate;
    logic [23:0] mcount;
    logic [23:0] mval;
    logic mprev;
    logic irq;
  } state_s;

  state_s q, d;
  logic [3:0] gen_in;
  logic [3:0] lane;
  logic [3:0][CTL_DIV_W-1:0] div_set;
  logic xfer_done;
  logic wr_ok;
  logic [EV_W-1:0] ev_set;
  logic [23:0] upper;
  logic tick;
  logic meas_start;

  assign gen_in = {i_generator_output_d, i_generator_output_c,
                   i_generator_output_b, i_generator_output_a};

  // ----------------------------------------------------------------
  // lane post-dividers
  // ----------------------------------------------------------------
  // a divider change may cut one lane period short
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign div_set[g] = q.ctrl[CTL_DIV_LO + g*CTL_DIV_W +: CTL_DIV_W];
    lane_post_divider u_div (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_src(gen_in[g]),
      .i_shift(div_set[g]),
      .o_div(lane[g])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ev_set = '0;
    xfer_done = 1'b0;
    tick = (q.div == 8'(SER_HALF_CYCLES - 1));
    upper = q.ctrl[CTL_ECHO] ? q.ctrl : q.mval;
    wr_ok = i_psel && i_penable && q.pready && i_pwrite;
    // a fresh start must win over a gate that is still running
    meas_start = wr_ok && i_paddr == OFF_CONTROL_STATUS
                 && |i_pwdata[CTL_MEAS_HI:CTL_MEAS_LO];

    // apb: one wait state, then the transfer completes
    d.pready = i_psel && i_penable && !q.pready;
    d.pslverr = 1'b0;
    d.prdata = '0;
    // read data is zero outside the ready cycle, so no stale value leaks
    if (i_psel && i_penable && !q.pready) begin
      case (i_paddr)
        OFF_TABLE_ADDRESS: d.prdata = {24'h000000, q.addr};
        OFF_TABLE_ONE_DATA: d.prdata = {24'h000000, q.tab_one[q.addr]};
        OFF_TABLE_TWO_DATA: d.prdata = {24'h000000, q.tab_two[q.addr]};
        // status bits 7:3 read as zero
        OFF_CONTROL_STATUS: d.prdata = {upper, 5'h00, q.flags};
        OFF_EVENT_STATUS: d.prdata = {29'h0, q.ev};
        OFF_EVENT_MASK: d.prdata = {29'h0, q.mask};
        default: d.pslverr = 1'b1;
      endcase
    end

    // tables keep only the low byte; upper bits read back as zero
    if (wr_ok) begin
      case (i_paddr)
        OFF_TABLE_ADDRESS: d.addr = i_pwdata[7:0];
        OFF_TABLE_ONE_DATA: d.tab_one[q.addr] = i_pwdata[7:0];
        OFF_TABLE_TWO_DATA: d.tab_two[q.addr] = i_pwdata[7:0];
        OFF_EVENT_MASK: d.mask = i_pwdata[EV_W-1:0];
        OFF_CONTROL_STATUS: begin
          d.ctrl[CTL_DIV_LO-1:1] = i_pwdata[CTL_DIV_LO-1:1];
          d.ctrl[CTL_PROGRAM] = 1'b0;
          if (i_pwdata[CTL_DIV_LOAD]) begin
            d.ctrl[CTL_DIV_HI:CTL_DIV_LO] = i_pwdata[CTL_DIV_HI:CTL_DIV_LO];
          end // else dividers kept
          // a start during a transfer is dropped, not queued
          if (i_pwdata[CTL_PROGRAM] && q.st == SER_IDLE) begin
            d.st = SER_LOAD;
            d.chip = 1'b0;
            d.idx = XFER_FIRST;
            d.flags[STS_PROG_DONE] = 1'b0;
            d.flags[STS_PROG_ERR] = 1'b0;
          end
          if (|i_pwdata[CTL_MEAS_HI:CTL_MEAS_LO]) begin
            d.meas_run = 1'b1;
            d.flags[STS_MEAS_DONE] = 1'b0;
            d.gate = '0;
            d.mcount = '0;
            d.mprev = 1'b0;
            d.msel = i_pwdata[1] ? 2'h0 : i_pwdata[2] ? 2'h1 : i_pwdata[3] ? 2'h2 : 2'h3;
          end
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // serial programming: 8-bit register index then 8-bit data, msb first
    // ----------------------------------------------------------------
    d.div = (q.st == SER_IDLE || tick) ? 8'h00 : q.div + 8'h01;
    case (q.st)
      SER_IDLE: begin
        // link lines rest low between transfers
        d.sclk = 1'b0;
        d.sdata = 1'b0;
        d.sel_one = 1'b0;
        d.sel_two = 1'b0;
      end
      SER_LOAD: begin
        d.shreg = {q.idx, q.chip ? q.tab_two[q.idx] : q.tab_one[q.idx]};
        d.bits = XFER_BITS;
        d.sel_one = !q.chip;
        d.sel_two = q.chip;
        d.sdata = d.shreg[15];
        d.st = SER_SHIFT;
      end
      SER_SHIFT: begin
        if (tick) begin
          d.sclk = !q.sclk;
          if (q.sclk) begin
            d.shreg = {q.shreg[14:0], 1'b0};
            d.bits = q.bits - 5'h01;
            d.sdata = d.shreg[15];
            if (q.bits == 5'h01) begin
              d.st = SER_ACK;
            end
          end
        end
      end
      SER_ACK: begin
        if (tick) begin
          // a missing acknowledge is flagged; the rest of the table still goes out
          if (!i_synth_ack) begin
            d.flags[STS_PROG_ERR] = 1'b1;
            ev_set[EV_PROG_ERR] = 1'b1;
          end
          d.st = SER_NEXT;
        end
      end
      SER_NEXT: begin
        // chip two follows chip one over the same index range
        d.st = SER_LOAD;
        d.idx = q.idx + 8'h01;
        if (q.idx == XFER_LAST) begin
          d.idx = XFER_FIRST;
          d.chip = 1'b1;
          if (q.chip) begin
            xfer_done = 1'b1; // both chips finished
          end
        end
      end
      default: d.st = SER_IDLE;
    endcase
    if (xfer_done) begin
      d.st = SER_IDLE;
      d.sel_one = 1'b0;
      d.sel_two = 1'b0;
      d.flags[STS_PROG_DONE] = 1'b1;
      ev_set[EV_PROG_DONE] = 1'b1;
    end

    // ----------------------------------------------------------------
    // measurement: edges per 100 ms gate give one tenth of the frequency
    // only lanes below half the system clock can be counted
    // the count keeps 24 bits, enough for any lane this logic can sample
    // ----------------------------------------------------------------
    if (q.meas_run && !meas_start) begin
      d.mprev = lane[q.msel];
      if (lane[q.msel] && !q.mprev) begin
        d.mcount = q.mcount + 24'h000001;
      end
      d.gate = q.gate + 32'h00000001;
      if (q.gate == GATE_COUNT - 32'h00000001) begin
        d.meas_run = 1'b0;
        d.mval = d.mcount;
        d.flags[STS_MEAS_DONE] = 1'b1;
        ev_set[EV_MEAS_DONE] = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // sticky events: write one clears, a same-cycle set wins
    // ----------------------------------------------------------------
    if (wr_ok && i_paddr == OFF_EVENT_STATUS) begin
      d.ev = q.ev & ~i_pwdata[EV_W-1:0];
    end
    d.ev = d.ev | ev_set;
    d.irq = |(d.ev & d.mask);
  end

  // tables clear to zero, not to generator defaults: software fills them first
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      q <= '0;
      q.ctrl <= RST_CONTROL;
      q.flags <= RST_FLAGS;
      q.mask <= RST_MASK;
      q.st <= SER_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_synth_sclk = q.sclk;
  assign o_synth_sdata = q.sdata;
  assign o_synth_sel_one = q.sel_one;
  assign o_synth_sel_two = q.sel_two;
  // lane outputs come straight from the divider flops
  assign o_lane1_baud_source = lane[0];
  assign o_lane2_baud_source = lane[1];
  assign o_lane3_baud_source = lane[2];
  assign o_lane4_baud_source = lane[3];
  assign o_irq = q.irq;

endmodule // clock_synth_program_ctrl

/* File: clock_synth_program_ctrl_monitor.sv */
// checker: bus and serial link properties of the synth controller
`timescale 1ns/1ns
module clock_synth_program_ctrl_monitor
  import synth_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // serial link
  input wire logic o_synth_sclk,
  input wire logic o_synth_sdata,
  input wire logic o_synth_sel_one,
  input wire logic o_synth_sel_two
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held past one cycle");
  ready_timing_a: assert property ($rose(i_penable) && i_psel |=> o_pready)
    else $error("ready late");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
  start_select_a: assert property (i_psel && i_penable && o_pready && i_pwrite
    && i_paddr == OFF_CONTROL_STATUS && i_pwdata[0] && !o_synth_sel_one && !o_synth_sel_two
    |-> ##2 o_synth_sel_one)
    else $error("start did not select first chip");
  sel_exclusive_a: assert property (!(o_synth_sel_one && o_synth_sel_two))
    else $error("both chips selected");
  sclk_high_a: assert property ($rose(o_synth_sclk) |-> ##49 o_synth_sclk ##1 !o_synth_sclk)
    else $error("serial clock high time wrong");
  sdata_stable_a: assert property (o_synth_sclk && $past(o_synth_sclk) |-> $stable(o_synth_sdata))
    else $error("serial data moved while clock high");
  sclk_idle_a: assert property (!o_synth_sel_one && !o_synth_sel_two |-> !o_synth_sclk)
    else $error("serial clock runs outside transfer");
endmodule // clock_synth_program_ctrl_monitor

bind clock_synth_program_ctrl clock_synth_program_ctrl_monitor u_mon (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_synth_sclk(o_synth_sclk),
  .o_synth_sdata(o_synth_sdata), .o_synth_sel_one(o_synth_sel_one),
  .o_synth_sel_two(o_synth_sel_two));

/* File: clock_synth_program_ctrl_tb.sv */
// testbench: registers, measurement, interrupt and programming of the synth controller
`timescale 1ns/1ns
module clock_synth_program_ctrl_tb
  import synth_ctrl_pkg::*;
;
  localparam int GATE = 1000;
  logic clk, rst, psel, pen, pwr, sclk, sdata, sel1, sel2, irq, ack, ack_bad, err, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ctl, d;
  logic [3:0] gen, lane;
  logic [7:0] t1 [256];
  logic [7:0] t2 [256];
  logic [15:0] word;
  int mismatches, check_count, seed, n, e, c;
  logic lp;

  clock_synth_program_ctrl #(.GATE_COUNT(32'(GATE))) u_clock_synth_program_ctrl (
    .i_clk_sys(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_generator_output_a(gen[0]), .i_generator_output_b(gen[1]),
    .i_generator_output_c(gen[2]), .i_generator_output_d(gen[3]), .i_synth_ack(ack),
    .o_synth_sclk(sclk), .o_synth_sdata(sdata), .o_synth_sel_one(sel1),
    .o_synth_sel_two(sel2), .o_lane1_baud_source(lane[0]), .o_lane2_baud_source(lane[1]),
    .o_lane3_baud_source(lane[2]), .o_lane4_baud_source(lane[3]), .o_irq(irq));
  synth_gen_model u_synth_gen_model (.i_clk_sys(clk), .i_ack_bad(ack_bad), .i_sel_one(sel1),
    .i_sel_two(sel2), .o_gen(gen), .o_ack(ack));

  // ----------------------------------------------------------------
  // report and compare
  // ----------------------------------------------------------------
  task automatic results();
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic timeout(input string nm);
    mismatches++;
    $display("[FAIL] %s expected done seen timeout", nm);
    results();
  endtask

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) timeout("apb ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic poll(input int b, input int lim);
    int k;
    k = 0;
    do begin apb(1'b0, OFF_CONTROL_STATUS, 32'h0); k++; end while (rd[b] !== 1'b1 && k < lim);
    if (rd[b] !== 1'b1) timeout("status poll");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    seed = 32'h422e;
    {rst, ack_bad, psel, pen, pwr, paddr, pwdata} = {3'b100, 46'h0};
    mismatches = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
    chk("status reset", 32'h1, rd);
    // two images behind one address, upper data bits dropped
    for (int i = 0; i < 10; i++) begin
      n = (i == 0) ? 8 : ($random(seed) & 8'hFF);
      d = $random(seed);
      t1[n] = d[7:0];
      t2[n] = d[15:8];
      apb(1'b1, OFF_TABLE_ADDRESS, 32'(n));
      apb(1'b1, OFF_TABLE_ONE_DATA, d);
      apb(1'b1, OFF_TABLE_TWO_DATA, {d[31:8], t2[n]});
      apb(1'b0, OFF_TABLE_ONE_DATA, 32'h0);
      chk("table one", {24'h0, t1[n]}, rd);
      apb(1'b0, OFF_TABLE_TWO_DATA, 32'h0);
      chk("table two", {24'h0, t2[n]}, rd);
      apb(1'b0, OFF_TABLE_ADDRESS, 32'h0);
      chk("table address", 32'(n), rd);
    end
    apb(1'b0, 12'h0B8, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    ctl = ($random(seed) & 32'hFFFFFF00) | 32'hC0;
    apb(1'b1, OFF_CONTROL_STATUS, ctl);
    apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
    chk("echo load", {ctl[23:0], 8'h01}, rd);
    d = ($random(seed) & 32'hFFFFFF00) | 32'h40;
    apb(1'b1, OFF_CONTROL_STATUS, d);
    apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
    chk("echo keep", {ctl[23:8], 8'h40, 8'h01}, rd);
    // each lane measured through a random divider
    for (int l = 0; l < 4; l++) begin
      n = ($random(seed) & 32'h7FFFFFFF) % 3;
      apb(1'b1, OFF_CONTROL_STATUS, (32'(n) << (8 + 4 * l)) | 32'h80 | (32'h2 << l));
      apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
      chk("meas running", 32'h0, {31'h0, rd[2]});
      poll(2, 400);
      e = GATE / ((4 + 2 * l) << n);
      chk_rng("meas value", e - 2, e + 2, {8'h0, rd[31:8]});
      c = 0;
      lp = lane[l];
      repeat (400) begin
        @(posedge clk);
        if (lane[l] && !lp) c++;
        lp = lane[l];
      end
      e = 400 / ((4 + 2 * l) << n);
      chk_rng("lane clock", e - 1, e + 1, 32'(c));
    end
    apb(1'b0, OFF_EVENT_STATUS, 32'h0);
    chk("event status", 32'h4, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_EVENT_MASK, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_EVENT_STATUS, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // refused acknowledge, repeated start while busy
    ack_bad <= 1'b1;
    apb(1'b1, OFF_CONTROL_STATUS, 32'h1);
    apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
    chk("prog busy", 32'h0, {31'h0, rd[0]});
    apb(1'b1, OFF_CONTROL_STATUS, 32'h1);
    chk("chip one selected", 32'h1, {31'h0, sel1});
    for (int b = 15; b >= 0; b--) begin
      n = 0;
      do begin @(posedge clk); n++; end while (sclk !== 1'b1 && n < 400);
      word[b] = sdata;
      do begin @(posedge clk); n++; end while (sclk !== 1'b0 && n < 400);
      if (n >= 400) timeout("serial clock");
    end
    chk("first word", {16'h0, 8'h08, t1[8]}, {16'h0, word});
    poll(1, 100);
    chk("prog still busy", 32'h0, {31'h0, rd[0]});
    apb(1'b0, OFF_EVENT_STATUS, 32'h0);
    chk("error event", 32'h2, rd);
    // reset in mid-transfer
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
    chk("status after reset", 32'h1, rd);
    chk("select after reset", 32'h0, {30'h0, sel1, sel2});
    results();
  end
endmodule // clock_synth_program_ctrl_tb

/* File: lane_post_divider.sv */
// module: power-of-two post-divider for one lane clock
`timescale 1ns/1ns
module lane_post_divider
  import synth_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // source and setting
  input wire logic i_src,
  input wire logic [CTL_DIV_W-1:0] i_shift,
  // divided lane clock
  output logic o_div
);

  typedef struct packed {
    logic prev;
    logic [14:0] cnt;
    logic out;
  } div_s;

  div_s q, d;
  logic [15:0] taps;

  // ----------------------------------------------------------------
  // counter bit n-1 toggles every 2^(n-1) rising edges: period 2^n
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.prev = i_src;
    if (i_src && !q.prev) begin
      d.cnt = q.cnt + 15'h0001;
    end
    taps = {d.cnt, i_src};
    d.out = taps[i_shift];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_div = q.out;

endmodule // lane_post_divider

/* File: synth_ctrl_pkg.sv */
// package: register map, field layout, reset values and timing for the clock synth controller
package synth_ctrl_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_TABLE_ADDRESS = 12'h0A0;
  localparam logic [11:0] OFF_TABLE_ONE_DATA = 12'h0A4;
  localparam logic [11:0] OFF_CONTROL_STATUS = 12'h0A8;
  localparam logic [11:0] OFF_TABLE_TWO_DATA = 12'h0AC;
  localparam logic [11:0] OFF_EVENT_STATUS = 12'h0B0;
  localparam logic [11:0] OFF_EVENT_MASK = 12'h0B4;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CTL_PROGRAM = 0;
  localparam int CTL_MEAS_LO = 1;
  localparam int CTL_MEAS_HI = 4;
  localparam int CTL_ECHO = 6;
  localparam int CTL_DIV_LOAD = 7;
  localparam int CTL_DIV_LO = 8;
  localparam int CTL_DIV_HI = 23;
  localparam int CTL_DIV_W = 4;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int STS_PROG_DONE = 0;
  localparam int STS_PROG_ERR = 1;
  localparam int STS_MEAS_DONE = 2;
  localparam int STS_FIELD_LO = 8;

  // event bits (status and mask share the layout)
  localparam int EV_PROG_DONE = 0;
  localparam int EV_PROG_ERR = 1;
  localparam int EV_MEAS_DONE = 2;
  localparam int EV_W = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RST_CONTROL = 24'h000000;
  localparam logic [2:0] RST_FLAGS = 3'h1;
  localparam logic [2:0] RST_MASK = 3'h0;

  // ----------------------------------------------------------------
  // table and serial transfer
  // ----------------------------------------------------------------
  localparam int TABLE_DEPTH = 256;
  localparam logic [7:0] XFER_FIRST = 8'h08;
  localparam logic [7:0] XFER_LAST = 8'h57;
  localparam logic [4:0] XFER_BITS = 5'h10;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SER_HALF_BIT_NS = 500;
  localparam int SER_HALF_CYCLES = SER_HALF_BIT_NS / CLK_PERIOD_NS;
  localparam int GATE_TIME_MS = 100;
  localparam int GATE_CYCLES = GATE_TIME_MS * (1000000 / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_LOAD = 3'b001,
    SER_SHIFT = 3'b010,
    SER_ACK = 3'b011,
    SER_NEXT = 3'b100
  } ser_state_e;

endpackage

/* File: synth_gen_model.sv */
// model: the two generator chips, their clock outputs and acknowledge
`timescale 1ns/1ns
module synth_gen_model (
  // clock and control
  input wire logic i_clk_sys,
  input wire logic i_ack_bad,
  input wire logic i_sel_one,
  input wire logic i_sel_two,
  // generator side
  output logic [3:0] o_gen,
  output logic o_ack
);
  logic [3:0] cnt [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
  logic [3:0] gen_q = 4'h0;
  assign o_gen = gen_q;
  // periods of 4, 6, 8 and 10 cycles, all under half the system rate
  always @(posedge i_clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (cnt[i] == 4'(i + 1)) begin
        cnt[i] <= 4'h0;
        gen_q[i] <= ~gen_q[i];
      end else begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
  // unselected line floats: shown as a toggling pattern
  assign o_ack = (i_sel_one || i_sel_two) ? ~i_ack_bad : o_gen[0];
endmodule // synth_gen_model
